// ### verilog/dsa_pkg.sv
// constants shared by the dual serial audio input ports
// ==========================================================================
// Notes on behaviour
// - three framing formats accepted on each port
// - rj/lj: word select high means left
// - data bit sampled on bit clock rise
// - rj: msb sixteen bit clocks after transition
// - rj, 64 clocks: lsb ends before transition
// - i2s: word select low means left
// - i2s: msb one bit clock after transition
// - lj: msb in first bit clock period
// - sample words forwarded to digital mixer path
// - each port runs at its own rate
package dsa_pkg;
	// ======================================================================
	// geometry
	localparam int DSA_NUM_PORTS = 2;
	localparam int DSA_WORD_W = 16;
	localparam int DSA_CNT_W = 6;
	localparam int DSA_SYNC_STAGES = 3;
	localparam int DSA_BUF_DEPTH = 2;
	// ======================================================================
	// format select encoding
	localparam logic [1:0] DSA_FMT_RJ = 2'h0;
	localparam logic [1:0] DSA_FMT_I2S = 2'h1;
	localparam logic [1:0] DSA_FMT_LJ = 2'h2;
	// ======================================================================
	// msb position in bit clock periods after a word select transition
	localparam logic [5:0] DSA_RJ_MSB_DELAY = 6'h10;
	localparam logic [5:0] DSA_I2S_MSB_DELAY = 6'h01;
	localparam logic [5:0] DSA_LJ_MSB_DELAY = 6'h00;
	localparam logic [5:0] DSA_CNT_MAX = 6'h3f;
	// ======================================================================
	// reset values
	localparam logic [15:0] DSA_WORD_RST = 16'h0000;
	localparam logic [5:0] DSA_CNT_RST = 6'h3f;
	localparam logic [2:0] DSA_SYNC_RST = 3'h0;
	// link bit clock period in the bench, ns, and the core clock rate
	localparam int DSA_REF_CLK_MHZ = 125;
	localparam int DSA_LINK_PERIOD_NS = 80;
	localparam int DSA_LINK_PERIOD_CYC = (DSA_LINK_PERIOD_NS * DSA_REF_CLK_MHZ) / 1000;
endpackage : dsa_pkg

// ### verilog/dsa_serial_in.sv
// dual serial audio input ports feeding the digital mixer
`timescale 1ns/10ps
module dsa_serial_in
	import dsa_pkg::*;
#(
	parameter int NUM_PORTS = DSA_NUM_PORTS,
	parameter int WORD_W = DSA_WORD_W
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic [NUM_PORTS-1:0] bit_clock_i,
	input wire logic [NUM_PORTS-1:0] word_select_i,
	input wire logic [NUM_PORTS-1:0] serial_data_i,
	input wire logic [NUM_PORTS-1:0] port_enable_i,
	input wire logic [NUM_PORTS-1:0][1:0] format_sel_i,
	output logic [NUM_PORTS-1:0] smp_valid_o,
	input wire logic [NUM_PORTS-1:0] smp_ready_i,
	output logic [NUM_PORTS-1:0][WORD_W-1:0] smp_left_o,
	output logic [NUM_PORTS-1:0][WORD_W-1:0] smp_right_o,
	output logic [NUM_PORTS-1:0] overrun_o
);

	// ======================================================================
	// helpers
	function automatic logic [5:0] msb_delay(input logic [1:0] fmt);
		logic [5:0] d;
		d = DSA_LJ_MSB_DELAY;
		if (fmt == DSA_FMT_RJ) begin
			d = DSA_RJ_MSB_DELAY;
		end else if (fmt == DSA_FMT_I2S) begin
			d = DSA_I2S_MSB_DELAY;
		end
		return d;
	endfunction : msb_delay

	function automatic logic is_left(input logic [1:0] fmt, input logic ws);
		logic l;
		l = ws;
		if (fmt == DSA_FMT_I2S) begin
			l = ~ws;
		end
		return l;
	endfunction : is_left

	// ======================================================================
	// pin synchronisers: three stages, a level counts once stages two and
	// three agree; the first stage feeds only the second
	logic [NUM_PORTS-1:0][2:0] bclk_sync_r;
	logic [NUM_PORTS-1:0][2:0] ws_sync_r;
	logic [NUM_PORTS-1:0][2:0] dat_sync_r;
	logic [NUM_PORTS-1:0] bclk_lvl_r;
	logic [NUM_PORTS-1:0] ws_lvl_r;
	logic [NUM_PORTS-1:0] dat_lvl_r;
	logic [NUM_PORTS-1:0] bclk_rise;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			bclk_sync_r <= '0;
			ws_sync_r <= '0;
			dat_sync_r <= '0;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				bclk_sync_r[p] <= {bclk_sync_r[p][1:0], bit_clock_i[p]};
				ws_sync_r[p] <= {ws_sync_r[p][1:0], word_select_i[p]};
				dat_sync_r[p] <= {dat_sync_r[p][1:0], serial_data_i[p]};
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			bclk_lvl_r <= '0;
			ws_lvl_r <= '0;
			dat_lvl_r <= '0;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (bclk_sync_r[p][1] == bclk_sync_r[p][2]) begin
					bclk_lvl_r[p] <= bclk_sync_r[p][2];
				end
				if (ws_sync_r[p][1] == ws_sync_r[p][2]) begin
					ws_lvl_r[p] <= ws_sync_r[p][2];
				end
				if (dat_sync_r[p][1] == dat_sync_r[p][2]) begin
					dat_lvl_r[p] <= dat_sync_r[p][2];
				end
			end
		end
	end

	// data and word select are taken at the filtered rising bit clock edge;
	// all three pins pass the same filter, but word select and data are read from their registered levels, one core cycle older than the edge
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			bclk_rise[p] = bclk_sync_r[p][1] & bclk_sync_r[p][2] & ~bclk_lvl_r[p];
		end
	end

	// ======================================================================
	// bit position counter, restarted by each word select transition
	logic [NUM_PORTS-1:0] ws_prev_r;
	logic [NUM_PORTS-1:0][5:0] pos_r;
	logic [NUM_PORTS-1:0] ws_edge;
	logic [NUM_PORTS-1:0][5:0] pos_now;

	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			ws_edge[p] = ws_lvl_r[p] ^ ws_prev_r[p];
			pos_now[p] = ws_edge[p] ? 6'h00 : pos_r[p];
		end
	end

	// each port counts on its own bit clock only, so rates are independent
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			ws_prev_r <= '0;
			pos_r <= {NUM_PORTS{DSA_CNT_RST}};
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (bclk_rise[p]) begin
					ws_prev_r[p] <= ws_lvl_r[p];
					if (pos_now[p] != DSA_CNT_MAX) begin
						pos_r[p] <= pos_now[p] + 6'h01;
					end else begin
						pos_r[p] <= DSA_CNT_MAX;
					end
				end
			end
		end
	end

	// ======================================================================
	// word assembly: sixteen bits msb first from the format's msb slot
	logic [NUM_PORTS-1:0][WORD_W-1:0] shift_r;
	logic [NUM_PORTS-1:0][WORD_W-1:0] left_r;
	logic [NUM_PORTS-1:0] left_ok_r;
	logic [NUM_PORTS-1:0] pair_done;
	logic [NUM_PORTS-1:0] in_word;
	logic [NUM_PORTS-1:0] last_bit;
	logic [NUM_PORTS-1:0][WORD_W-1:0] word_now;

	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			in_word[p] = (pos_now[p] >= msb_delay(format_sel_i[p])) &&
				(pos_now[p] < msb_delay(format_sel_i[p]) + 6'(WORD_W));
			last_bit[p] = pos_now[p] == msb_delay(format_sel_i[p]) + 6'(WORD_W - 1);
			word_now[p] = {shift_r[p][WORD_W-2:0], dat_lvl_r[p]};
			pair_done[p] = bclk_rise[p] & in_word[p] & last_bit[p] & port_enable_i[p] &
				~is_left(format_sel_i[p], ws_lvl_r[p]) & left_ok_r[p];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			shift_r <= {NUM_PORTS{DSA_WORD_RST}};
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (bclk_rise[p] && in_word[p]) begin
					shift_r[p] <= word_now[p];
				end
			end
		end
	end

	// a right word only pairs with a left word from the same frame
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			left_r <= {NUM_PORTS{DSA_WORD_RST}};
			left_ok_r <= '0;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (!port_enable_i[p]) begin
					left_ok_r[p] <= 1'b0;
				end else if (bclk_rise[p] && in_word[p] && last_bit[p]) begin
					if (is_left(format_sel_i[p], ws_lvl_r[p])) begin
						left_r[p] <= word_now[p];
						left_ok_r[p] <= 1'b1;
					end else begin
						left_ok_r[p] <= 1'b0;
					end
				end
			end
		end
	end

	// ======================================================================
	// two-entry pair buffer toward the mixer; a stall of up to two full
	// frames loses nothing, a longer stall drops the newest pair
	logic [NUM_PORTS-1:0][DSA_BUF_DEPTH-1:0][WORD_W-1:0] buf_l_r;
	logic [NUM_PORTS-1:0][DSA_BUF_DEPTH-1:0][WORD_W-1:0] buf_r_r;
	logic [NUM_PORTS-1:0] wr_ptr_r;
	logic [NUM_PORTS-1:0] rd_ptr_r;
	logic [NUM_PORTS-1:0][1:0] fill_r;
	logic [NUM_PORTS-1:0] push;
	logic [NUM_PORTS-1:0] pop;
	logic [NUM_PORTS-1:0] full;

	// valid is settled before pop reads it; a pop in the cycle a pair
	// completes frees the slot, so a full buffer being drained drops nothing
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			smp_valid_o[p] = fill_r[p] != 2'h0;
			full[p] = fill_r[p] == 2'(DSA_BUF_DEPTH);
			pop[p] = smp_valid_o[p] & smp_ready_i[p];
			push[p] = pair_done[p] & (~full[p] | pop[p]);
			smp_left_o[p] = buf_l_r[p][rd_ptr_r[p]];
			smp_right_o[p] = buf_r_r[p][rd_ptr_r[p]];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			buf_l_r <= '0;
			buf_r_r <= '0;
			wr_ptr_r <= '0;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (push[p]) begin
					buf_l_r[p][wr_ptr_r[p]] <= left_r[p];
					buf_r_r[p][wr_ptr_r[p]] <= word_now[p];
					wr_ptr_r[p] <= ~wr_ptr_r[p];
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			rd_ptr_r <= '0;
			fill_r <= '0;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (pop[p]) begin
					rd_ptr_r[p] <= ~rd_ptr_r[p];
				end
				if (push[p] && !pop[p]) begin
					fill_r[p] <= fill_r[p] + 2'h1;
				end else if (pop[p] && !push[p]) begin
					fill_r[p] <= fill_r[p] - 2'h1;
				end
			end
		end
	end

	// one-cycle pulse when a finished pair found the buffer full
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			overrun_o <= '0;
		end else begin
			overrun_o <= pair_done & ~push;
		end
	end

endmodule : dsa_serial_in

// ### tb/dsa_serial_in_monitor.sv
// checker for the dual serial audio input ports
`timescale 1ns/10ps
module dsa_serial_in_mon
	import dsa_pkg::*;
#(
	parameter int NUM_PORTS = DSA_NUM_PORTS,
	parameter int WORD_W = DSA_WORD_W
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic [NUM_PORTS-1:0] bit_clock_i,
	input wire logic [NUM_PORTS-1:0] word_select_i,
	input wire logic [NUM_PORTS-1:0] serial_data_i,
	input wire logic [NUM_PORTS-1:0] port_enable_i,
	input wire logic [NUM_PORTS-1:0][1:0] format_sel_i,
	input wire logic [NUM_PORTS-1:0] smp_valid_o,
	input wire logic [NUM_PORTS-1:0] smp_ready_i,
	input wire logic [NUM_PORTS-1:0][WORD_W-1:0] smp_left_o,
	input wire logic [NUM_PORTS-1:0][WORD_W-1:0] smp_right_o,
	input wire logic [NUM_PORTS-1:0] overrun_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	// ======================================================================
	// properties
	property p_rst; disable iff (1'b0) !rst_b_i |=> smp_valid_o == '0 && overrun_o == '0; endproperty
	property p_hold0; smp_valid_o[0] && !smp_ready_i[0] |=> smp_valid_o[0]
		&& $stable(smp_left_o[0]) && $stable(smp_right_o[0]); endproperty
	property p_hold1; smp_valid_o[1] && !smp_ready_i[1] |=> smp_valid_o[1]
		&& $stable(smp_left_o[1]) && $stable(smp_right_o[1]); endproperty
	// a pair may only leave the port by being taken
	property p_pop0; $fell(smp_valid_o[0]) |-> $past(smp_ready_i[0]); endproperty
	property p_pop1; $fell(smp_valid_o[1]) |-> $past(smp_ready_i[1]); endproperty
	property p_ovr_pulse; overrun_o[0] |=> !overrun_o[0]; endproperty
	property p_ovr_full; overrun_o[0] |-> smp_valid_o[0]; endproperty
	property p_en0; $rose(smp_valid_o[0]) |-> $past(port_enable_i[0]); endproperty
	a_rst: assert property (p_rst) else $error("outputs active in reset");
	a_hold0: assert property (p_hold0) else $error("port 0 pair moved");
	a_hold1: assert property (p_hold1) else $error("port 1 pair moved");
	a_pop0: assert property (p_pop0) else $error("port 0 pop lost");
	a_pop1: assert property (p_pop1) else $error("port 1 pop lost");
	a_ovr_pulse: assert property (p_ovr_pulse) else $error("overrun too long");
	a_ovr_full: assert property (p_ovr_full) else $error("overrun with room");
	a_en0: assert property (p_en0) else $error("pair from disabled port");
	c_ovr: cover property (overrun_o[0]);
	c_pop0: cover property (smp_valid_o[0] && smp_ready_i[0]);
	c_pop1: cover property (smp_valid_o[1] && smp_ready_i[1]);
endmodule : dsa_serial_in_mon
bind dsa_serial_in dsa_serial_in_mon #(.NUM_PORTS(NUM_PORTS), .WORD_W(WORD_W)) u_mon (
	.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .bit_clock_i(bit_clock_i),
	.word_select_i(word_select_i), .serial_data_i(serial_data_i),
	.port_enable_i(port_enable_i), .format_sel_i(format_sel_i), .smp_valid_o(smp_valid_o),
	.smp_ready_i(smp_ready_i), .smp_left_o(smp_left_o), .smp_right_o(smp_right_o),
	.overrun_o(overrun_o));

// ### tb/dsa_src_model.sv
// serial audio source driving one port
`timescale 1ns/10ps
module dsa_src_model
	import dsa_pkg::*;
(
	output logic bclk_o,
	output logic ws_o,
	output logic sd_o
);
	// clock stands low between frames
	initial begin
		bclk_o = 1'b0;
		ws_o = 1'b0;
		sd_o = 1'b0;
	end
	// one lead half with right-level select forces a fresh transition
	task automatic send(input logic [1:0] fmt, input logic [15:0] l, input logic [15:0] r);
		int d;
		logic lft;
		d = (fmt == DSA_FMT_RJ) ? 16 : (fmt == DSA_FMT_I2S) ? 1 : 0;
		lft = (fmt != DSA_FMT_I2S);
		for (int h = -1; h < 2; h++) begin
			for (int p = 0; p < 32; p++) begin
				bclk_o = 1'b0;
				ws_o = (h == 0) ? lft : ~lft;
				// outside the word the line toggles, never repeats the lsb
				if (h >= 0 && p >= d && p < d + 16) begin
					sd_o = (h == 0) ? l[15-(p-d)] : r[15-(p-d)];
				end else begin
					sd_o = ~sd_o;
				end
				#40 bclk_o = 1'b1;
				#40;
			end
		end
		bclk_o = 1'b0;
	endtask : send
endmodule : dsa_src_model

// ### tb/dsa_serial_in_tb_top.sv
// testbench for the dual serial audio input ports
`timescale 1ns/10ps
module dsa_serial_in_tb_top
	import dsa_pkg::*;
;
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [1:0] en = 2'h3;
	logic [1:0] rdy = 2'h0;
	logic [1:0][1:0] fmt = '0;
	logic [1:0] valid, ovr;
	logic [1:0][15:0] lw, rw;
	wire logic [1:0] bclk, ws, sd;
	int fail_count = 0;
	int n_tests = 0;
	int ovr_n = 0;
	int ovr1_n = 0;
	always #4 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) if (ovr[0] === 1'b1) ovr_n++;
	always @(posedge ref_clk_i) if (ovr[1] === 1'b1) ovr1_n++;
	dsa_src_model s0 (.bclk_o(bclk[0]), .ws_o(ws[0]), .sd_o(sd[0]));
	dsa_src_model s1 (.bclk_o(bclk[1]), .ws_o(ws[1]), .sd_o(sd[1]));
	dsa_serial_in dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .bit_clock_i(bclk),
		.word_select_i(ws), .serial_data_i(sd), .port_enable_i(en), .format_sel_i(fmt),
		.smp_valid_o(valid), .smp_ready_i(rdy), .smp_left_o(lw), .smp_right_o(rw),
		.overrun_o(ovr));
	// ======================================================================
	// shared tasks
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic pop_chk(input int p, input logic [31:0] e);
		int k;
		k = 0;
		while (valid[p] !== 1'b1 && k < 100) begin
			@(posedge ref_clk_i);
			#1 k++;
		end
		if (valid[p] !== 1'b1) begin
			fail_count++;
			final_report();
		end
		chk("pair", e, {lw[p], rw[p]});
		rdy[p] = 1'b1;
		@(posedge ref_clk_i);
		#1 rdy[p] = 1'b0;
	endtask : pop_chk
	// ======================================================================
	// scenarios
	task automatic t_formats();
		for (int f = 0; f < 4; f++) begin
			fmt[0] = 2'(f);
			fmt[1] = 2'(f + 1);
			fork
				s0.send(2'(f), 16'h8001 ^ 16'(f), 16'h7ffe ^ 16'(f));
				s1.send(2'(f + 1), 16'hc35a + 16'(f), 16'h0ff0 - 16'(f));
			join
			pop_chk(0, {16'h8001 ^ 16'(f), 16'h7ffe ^ 16'(f)});
			pop_chk(1, {16'hc35a + 16'(f), 16'h0ff0 - 16'(f)});
		end
		chk("port 1 overruns", 32'h0, 32'(ovr1_n));
		$display("formats done");
	endtask : t_formats
	task automatic t_overrun();
		fmt[0] = DSA_FMT_LJ;
		ovr_n = 0;
		for (int i = 0; i < 3; i++) s0.send(DSA_FMT_LJ, 16'h1111 * 16'(i + 1), 16'(i));
		chk("overruns", 32'h1, 32'(ovr_n));
		pop_chk(0, {16'h1111, 16'h0000});
		pop_chk(0, {16'h2222, 16'h0001});
		chk("empty", 32'h0, {31'h0, valid[0]});
		$display("overrun done");
	endtask : t_overrun
	task automatic t_disable();
		en = 2'h2;
		s0.send(DSA_FMT_RJ, 16'hdead, 16'hbeef);
		repeat (20) @(posedge ref_clk_i);
		#1 chk("disabled", 32'h0, {31'h0, valid[0]});
		en = 2'h3;
		$display("disable done");
	endtask : t_disable
	initial begin
		repeat (4) @(posedge ref_clk_i);
		#1 rst_b_i = 1'b1;
		t_formats();
		t_overrun();
		t_disable();
		final_report();
	end
endmodule : dsa_serial_in_tb_top
